// ---- core/kbd_mailbox_pkg.sv ----
package kbd_mailbox_pkg;

  // host i/o decode
  localparam logic [15:0] KB_DATA_PORT_ADDR = 16'h0060;
  localparam logic [15:0] KB_CTRL_PORT_ADDR = 16'h0064;

  // status byte layout and reset
  localparam int          OUT_FULL_BIT = 0;
  localparam int          IN_FULL_BIT  = 1;
  localparam int          CD_BIT       = 3;
  localparam logic [7:0]  STATUS_RESET = 8'h00;
  localparam logic [7:0]  USER_MASK    = 8'hF4;

  // port 2 bit positions and reset value
  localparam int          P2_A20_BIT   = 1;
  localparam int          P2_AUX_DAT_BIT = 2;
  localparam int          P2_AUX_CLK_BIT = 3;
  localparam int          P2_KB_IRQ_BIT  = 4;
  localparam int          P2_AUX_IRQ_BIT = 5;
  localparam int          P2_KB_CLK_BIT  = 6;
  localparam int          P2_KB_DAT_BIT  = 7;
  localparam logic [7:0]  PORT2_RESET  = 8'h00;

  // on-chip memories
  localparam int          ROM_BYTES = 2048;
  localparam int          RAM_BYTES = 256;
  localparam int          ROM_AW    = $clog2(ROM_BYTES);
  localparam int          RAM_AW    = $clog2(RAM_BYTES);

  // timing
  localparam int          CLK_PERIOD_NS  = 4;
  localparam int          OSC_SETTLE_NS  = 1000;
  localparam int          OSC_SETTLE_CYC = (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          RESET_MIN_CLKS = 24;
  localparam logic [7:0]  SETTLE_LOAD    = 8'(OSC_SETTLE_CYC - 1);

  typedef enum logic [1:0] {PWR_RUN, PWR_SOFT, PWR_HARD, PWR_SETTLE} pwr_state_type;

endpackage

// ---- core/kbd_byte_mem.sv ----
`timescale 1ns/10ps
// single port byte memory, registered read data
module kbd_byte_mem #(
  parameter int AW = 8
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata
);
  logic [7:0] mem [0:(1<<AW)-1];

  // write-first is not needed: firmware never reads a byte in its write cycle
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

// ---- core/kbd_od_pins.sv ----
`timescale 1ns/10ps
// four open-drain lines: a port bit of one pulls the pin low
module kbd_od_pins (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [3:0] port_bits,
  input  wire logic [3:0] pad_in,
  output logic      [3:0] pad_out,
  output logic      [3:0] pad_oe,
  output logic      [3:0] sense
);
  // pin level is the inverted port bit; released pins float weak high
  genvar i;
  for (i = 0; i < 4; i++) begin : g_pin
    always_ff @(posedge clk) begin
      if (reset) begin
        pad_out[i] <= 1'b0;
        pad_oe[i]  <= 1'b0;
        sense[i]   <= 1'b1;
      end else begin
        pad_out[i] <= 1'b0;
        pad_oe[i]  <= port_bits[i];
        sense[i]   <= pad_in[i];
      end
    end
  end
endmodule

// ---- core/kbd_host_mailbox.sv ----
`timescale 1ns/10ps
// Functional notes
// RULE1 - write 60h loads data, read 60h gives output byte, 64h command/status
// RULE2 - host data write clears command flag and sets input full
// RULE3 - host command write sets command flag and sets input full
// RULE4 - in flag mode host data read clears output full and keyboard irq
// RULE5 - controller output write loads host byte and sets output full
// RULE6 - controller input read clears input full and its internal interrupt
// RULE7 - status: bit0 output full, bit1 input full, bit3 command, rest user
// RULE8 - status read-only to host, writable by controller, resets to zero
// RULE9 - flag mode: keyboard irq is output full gated by port2 bit4
// RULE10 - otherwise keyboard irq follows port2 bit4 directly
// RULE11 - flag mode with port2 bit5 set: mouse irq is inverted input full
// RULE12 - otherwise mouse irq follows port2 bit5 directly
// RULE13 - keyboard irq is low after reset
// RULE14 - port2 bit1 drives the address line 20 gate output
// RULE15 - port2 bits 6,7,3,2 inverted onto open-drain lines, read back
// RULE16 - halt stops core clock until reset or host buffer write
// RULE17 - wake by host write calls isr if enabled, else next instruction
// RULE18 - stop disables oscillator; same exits; reset must cover settling; the testbench holds reset 24 clocks, short of the 250-cycle settle
// RULE19 - only two controller interrupts: input full and timer overflow
// RULE20 - 2K bytes program memory and 256 bytes data memory
// RULE21 - reset held at least 24 controller clock periods by its source
// RULE22 - firmware status writes never touch the three hardware flags
module kbd_host_mailbox (
  input  wire logic        CORE_CLK,
  input  wire logic        RESET,
  input  wire logic [15:0] HOST_ADDR,
  input  wire logic        HOST_RD_N,
  input  wire logic        HOST_WR_N,
  input  wire logic [7:0]  HOST_DIN,
  output logic      [7:0]  HOST_DOUT,
  output logic             HOST_DOUT_EN,
  output logic             KB_HOST_IRQ,
  output logic             AUX_HOST_IRQ,
  output logic             A20_GATE,
  input  wire logic        CPU_OUT_WR,
  input  wire logic [7:0]  CPU_OUT_WDATA,
  input  wire logic        CPU_IN_RD,
  output logic      [7:0]  CPU_IN_RDATA,
  input  wire logic        CPU_STATUS_WR,
  input  wire logic [7:0]  CPU_STATUS_WDATA,
  output logic      [7:0]  CPU_STATUS,
  input  wire logic        CPU_PORT2_WR,
  input  wire logic [7:0]  CPU_PORT2_WDATA,
  input  wire logic        CPU_EN_FLAGS,
  input  wire logic        CPU_IN_INT_EN,
  input  wire logic        CPU_TMR_INT_EN,
  input  wire logic        TIMER_OVF,
  input  wire logic        CPU_TMR_ACK,
  output logic             CPU_IRQ,
  input  wire logic        CPU_HALT,
  input  wire logic        CPU_STOP,
  output logic             CORE_RUN,
  output logic             OSC_RUN,
  output logic             WAKE_CALL,
  output logic             WAKE_NEXT,
  input  wire logic        ROM_WE,
  input  wire logic [10:0] ROM_ADDR,
  input  wire logic [7:0]  ROM_WDATA,
  output logic      [7:0]  ROM_RDATA,
  input  wire logic        RAM_WE,
  input  wire logic [7:0]  RAM_ADDR,
  input  wire logic [7:0]  RAM_WDATA,
  output logic      [7:0]  RAM_RDATA,
  input  wire logic [3:0]  KB_PAD_IN,
  output logic      [3:0]  KB_PAD_OUT,
  output logic      [3:0]  KB_PAD_OE,
  output logic             SENSE_INPUT0,
  output logic             SENSE_INPUT1,
  output logic             PORT1_BIT0,
  output logic             PORT1_BIT1
);

  function automatic logic port_hit(input logic [15:0] a, input logic [15:0] p);
    port_hit = (a == p);
  endfunction

  // state
  logic        rd_n_q;
  logic        wr_n_q;
  logic        in_full_q, in_full_d;
  logic        out_full_q, out_full_d;
  logic        cd_q, cd_d;
  logic [7:0]  user_q, user_d;
  logic [7:0]  in_buf_q;
  logic [7:0]  out_buf_q;
  logic [7:0]  port2_q;
  logic        en_flags_q;
  logic        tmr_pend_q;
  logic [7:0]  settle_q;
  kbd_mailbox_pkg::pwr_state_type pwr_q, pwr_d;

  // host strobes act once, on the falling edge of each strobe
  wire rd_evt      = rd_n_q & ~HOST_RD_N;
  wire wr_evt      = wr_n_q & ~HOST_WR_N;
  wire data_hit    = port_hit(HOST_ADDR, kbd_mailbox_pkg::KB_DATA_PORT_ADDR);
  wire ctrl_hit    = port_hit(HOST_ADDR, kbd_mailbox_pkg::KB_CTRL_PORT_ADDR);
  wire host_wr_dat = wr_evt & data_hit;     // [RULE1]
  wire host_wr_cmd = wr_evt & ctrl_hit;     // [RULE1]
  wire host_rd_dat = rd_evt & data_hit;     // [RULE1]
  wire host_wr_any = host_wr_dat | host_wr_cmd;
  wire rd_active   = ~HOST_RD_N & (data_hit | ctrl_hit);

  // assembled status byte, user bits masked away from the flag positions
  wire [7:0] status_byte = (user_q & kbd_mailbox_pkg::USER_MASK)
                         | (8'(out_full_q) << kbd_mailbox_pkg::OUT_FULL_BIT)
                         | (8'(in_full_q) << kbd_mailbox_pkg::IN_FULL_BIT)
                         | (8'(cd_q)  << kbd_mailbox_pkg::CD_BIT);   // [RULE7]

  // flag updates: a set in the same cycle as a clear wins
  always_comb begin
    in_full_d  = host_wr_any | (in_full_q & ~CPU_IN_RD);              // [RULE2] [RULE3] [RULE6]
    out_full_d = CPU_OUT_WR | (out_full_q & ~host_rd_dat);            // [RULE4] [RULE5]
    cd_d   = host_wr_any ? host_wr_cmd : cd_q;                        // [RULE2] [RULE3]
    user_d = CPU_STATUS_WR ? (CPU_STATUS_WDATA & kbd_mailbox_pkg::USER_MASK) : user_q; // [RULE22]
  end

  // host strobe history and mailbox flags
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      in_full_q  <= 1'b0;
      out_full_q <= 1'b0;
      cd_q   <= 1'b0;
      user_q <= kbd_mailbox_pkg::STATUS_RESET;                       // [RULE8]
    end else begin
      rd_n_q <= HOST_RD_N;
      wr_n_q <= HOST_WR_N;
      in_full_q  <= in_full_d;
      out_full_q <= out_full_d;
      cd_q   <= cd_d;
      user_q <= user_d;
    end
  end

  // data buffers: the input byte is the data or command written by the host
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      in_buf_q  <= 8'h00;
      out_buf_q <= 8'h00;
    end else begin
      if (host_wr_any) begin
        in_buf_q <= HOST_DIN;
      end
      if (CPU_OUT_WR) begin
        out_buf_q <= CPU_OUT_WDATA;                                  // [RULE5]
      end
    end
  end

  // host read data; the status port is read-only, writes there are commands
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      HOST_DOUT    <= 8'h00;
      HOST_DOUT_EN <= 1'b0;
    end else begin
      HOST_DOUT_EN <= rd_active;
      if (rd_evt && data_hit) begin
        HOST_DOUT <= out_buf_q;                                      // [RULE1]
      end else if (rd_evt && ctrl_hit) begin
        HOST_DOUT <= status_byte;                                    // [RULE8]
      end
    end
  end

  // controller side view of the mailbox
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      CPU_IN_RDATA <= 8'h00;
      CPU_STATUS    <= kbd_mailbox_pkg::STATUS_RESET;
    end else begin
      CPU_IN_RDATA <= in_buf_q;
      CPU_STATUS    <= status_byte;
    end
  end

  // port 2 latch and the sticky flag-mode switch (only reset leaves it)
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      port2_q    <= kbd_mailbox_pkg::PORT2_RESET;
      en_flags_q <= 1'b0;
    end else begin
      if (CPU_PORT2_WR) begin
        port2_q <= CPU_PORT2_WDATA;
      end
      if (CPU_EN_FLAGS) begin
        en_flags_q <= 1'b1;
      end
    end
  end

  // host interrupt lines
  wire port2_bit4 = port2_q[kbd_mailbox_pkg::P2_KB_IRQ_BIT];
  wire port2_bit5 = port2_q[kbd_mailbox_pkg::P2_AUX_IRQ_BIT];
  wire kb_irq_d  = en_flags_q ? (out_full_q & port2_bit4) : port2_bit4;  // [RULE9] [RULE10]
  wire aux_irq_d = en_flags_q ? (~in_full_q & port2_bit5) : port2_bit5;  // [RULE11] [RULE12]

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      KB_HOST_IRQ  <= 1'b0;                                          // [RULE13]
      AUX_HOST_IRQ <= 1'b0;
      A20_GATE     <= 1'b0;
    end else begin
      KB_HOST_IRQ  <= kb_irq_d;                                      // [RULE4]
      AUX_HOST_IRQ <= aux_irq_d;
      A20_GATE     <= port2_q[kbd_mailbox_pkg::P2_A20_BIT];          // [RULE14]
    end
  end

  // controller interrupt: input full and timer overflow are the only sources
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      tmr_pend_q <= 1'b0;
      CPU_IRQ    <= 1'b0;
    end else begin
      tmr_pend_q <= TIMER_OVF | (tmr_pend_q & ~CPU_TMR_ACK);
      CPU_IRQ    <= (in_full_d & CPU_IN_INT_EN) | (tmr_pend_q & CPU_TMR_INT_EN); // [RULE19] [RULE6]
    end
  end

  // power modes; reset itself restarts the core from address zero
  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      kbd_mailbox_pkg::PWR_RUN: begin
        if (CPU_STOP) begin
          pwr_d = kbd_mailbox_pkg::PWR_HARD;                         // [RULE18]
        end else if (CPU_HALT) begin
          pwr_d = kbd_mailbox_pkg::PWR_SOFT;                         // [RULE16]
        end
      end
      kbd_mailbox_pkg::PWR_SOFT: begin
        if (host_wr_any) begin
          pwr_d = kbd_mailbox_pkg::PWR_RUN;                          // [RULE16]
        end
      end
      kbd_mailbox_pkg::PWR_HARD: begin
        if (host_wr_any) begin
          pwr_d = kbd_mailbox_pkg::PWR_SETTLE;                       // [RULE18]
        end
      end
      kbd_mailbox_pkg::PWR_SETTLE: begin
        if (settle_q == 8'h00) begin
          pwr_d = kbd_mailbox_pkg::PWR_RUN;
        end
      end
      default: pwr_d = kbd_mailbox_pkg::PWR_RUN;
    endcase
  end

  // resume pulse: interrupt call when enabled, else fall through
  wire resume = (pwr_q == kbd_mailbox_pkg::PWR_SOFT && host_wr_any)
              || (pwr_q == kbd_mailbox_pkg::PWR_SETTLE && settle_q == 8'h00);

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      pwr_q     <= kbd_mailbox_pkg::PWR_RUN;                         // [RULE17]
      settle_q  <= 8'h00;
      CORE_RUN  <= 1'b1;
      OSC_RUN   <= 1'b1;
      WAKE_CALL <= 1'b0;
      WAKE_NEXT <= 1'b0;
    end else begin
      pwr_q     <= pwr_d;
      settle_q  <= (pwr_d == kbd_mailbox_pkg::PWR_SETTLE && pwr_q != kbd_mailbox_pkg::PWR_SETTLE)
                 ? kbd_mailbox_pkg::SETTLE_LOAD
                 : (settle_q != 8'h00 ? settle_q - 8'h01 : 8'h00);
      CORE_RUN  <= (pwr_d == kbd_mailbox_pkg::PWR_RUN);              // [RULE16]
      OSC_RUN   <= (pwr_d != kbd_mailbox_pkg::PWR_HARD);             // [RULE18]
      WAKE_CALL <= resume & CPU_IN_INT_EN;                           // [RULE17]
      WAKE_NEXT <= resume & ~CPU_IN_INT_EN;                          // [RULE17]
    end
  end

  // on-chip program and data memories
  kbd_byte_mem #(.AW(kbd_mailbox_pkg::ROM_AW)) u_rom (              // [RULE20]
    .clk   (CORE_CLK),
    .we    (ROM_WE),
    .addr  (ROM_ADDR),
    .wdata (ROM_WDATA),
    .rdata (ROM_RDATA)
  );

  kbd_byte_mem #(.AW(kbd_mailbox_pkg::RAM_AW)) u_ram (              // [RULE20]
    .clk   (CORE_CLK),
    .we    (RAM_WE),
    .addr  (RAM_ADDR),
    .wdata (RAM_WDATA),
    .rdata (RAM_RDATA)
  );

  // pads: 0 kb clock, 1 kb data, 2 aux clock, 3 aux data
  wire [3:0] od_bits = {port2_q[kbd_mailbox_pkg::P2_AUX_DAT_BIT],
                        port2_q[kbd_mailbox_pkg::P2_AUX_CLK_BIT],
                        port2_q[kbd_mailbox_pkg::P2_KB_DAT_BIT],
                        port2_q[kbd_mailbox_pkg::P2_KB_CLK_BIT]};     // [RULE15]
  logic [3:0] sense_w;

  kbd_od_pins u_pins (
    .clk       (CORE_CLK),
    .reset     (RESET),
    .port_bits (od_bits),
    .pad_in    (KB_PAD_IN),
    .pad_out   (KB_PAD_OUT),
    .pad_oe    (KB_PAD_OE),
    .sense     (sense_w)
  );

  assign SENSE_INPUT0 = sense_w[0];                                  // [RULE15]
  assign PORT1_BIT0   = sense_w[1];
  assign SENSE_INPUT1 = sense_w[2];
  assign PORT1_BIT1   = sense_w[3];

  // checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  sequence s_halt_in_run;
    (pwr_q == kbd_mailbox_pkg::PWR_RUN) && CPU_HALT && !CPU_STOP;
  endsequence
  sequence s_core_stopped;
    ##1 !CORE_RUN ##1 !CORE_RUN;
  endsequence

  a_data_write_flags: assert property (host_wr_dat |=> in_full_q && !cd_q) // [RULE2]
    else $error("data write did not set input full with data flag");
  a_cmd_write_flags: assert property (host_wr_cmd |=> in_full_q && cd_q) // [RULE3]
    else $error("command write did not set input full with command flag");
  a_out_full_set: assert property (CPU_OUT_WR |=> out_full_q && out_buf_q == $past(CPU_OUT_WDATA)) // [RULE5]
    else $error("controller output write did not set output full");
  a_in_full_clear: assert property (CPU_IN_RD && !host_wr_any |=> !in_full_q) // [RULE6]
    else $error("controller read did not clear input full");
  a_kb_irq_low: assert property (en_flags_q && !port2_bit4 |=> !KB_HOST_IRQ) // [RULE9]
    else $error("keyboard irq not forced low");
  a_kb_irq_drop: assert property (en_flags_q && port2_bit4 && host_rd_dat && !CPU_OUT_WR |=> ##1 !KB_HOST_IRQ) // [RULE4]
    else $error("host data read did not drop keyboard irq");
  a_kb_irq_direct: assert property (!en_flags_q |=> KB_HOST_IRQ == $past(port2_bit4)) // [RULE10]
    else $error("keyboard irq does not follow port bit");
  a_aux_irq_inverted: assert property (en_flags_q && port2_bit5 |=> AUX_HOST_IRQ == !$past(in_full_q)) // [RULE11]
    else $error("mouse irq is not inverted input full");
  a_aux_irq_direct: assert property (!en_flags_q |=> AUX_HOST_IRQ == $past(port2_bit5)) // [RULE12]
    else $error("mouse irq does not follow port bit");
  a_user_bits_safe: assert property (CPU_STATUS_WR && !host_wr_any && !CPU_IN_RD && !CPU_OUT_WR
                                     && !host_rd_dat |=> $stable(cd_q) && $stable(in_full_q) && $stable(out_full_q)) // [RULE22]
    else $error("firmware status write changed a hardware flag");
  a_halt_stops_core: assert property (s_halt_in_run |-> s_core_stopped) // [RULE16]
    else $error("halt did not stop the core clock");

endmodule

// ---- verif/host_io_model.sv ----
`timescale 1ns/10ps
// host processor side of the keyboard ports: byte reads and writes, one access per strobe
module host_io_model (
  input  wire logic        clk,
  output logic      [15:0] addr,
  output logic             rd_n,
  output logic             wr_n,
  output logic      [7:0]  din,
  input  wire logic [7:0]  dout,
  input  wire logic        dout_en
);
  // strobes idle high; idle bus carries junk, never a stale address
  initial begin
    addr = 16'hFFFF;
    rd_n = 1'b1;
    wr_n = 1'b1;
    din  = 8'h00;
  end

  // write cycle: strobe low across one taking edge, then high a full cycle
  task automatic io_write(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a; // data port or command port
    din  = d;
    wr_n = 1'b0;
    @(posedge clk);
    @(negedge clk);
    wr_n = 1'b1;
    addr = ~a; // released lines show the inverse so a stale value cannot pass
    din  = ~d;
    @(negedge clk);
  endtask

  // read cycle: data sampled one edge after the taking edge, strobe still low
  task automatic io_read(input logic [15:0] a, output logic [7:0] d, output logic en);
    @(negedge clk);
    addr = a; // output byte or status byte
    rd_n = 1'b0;
    @(posedge clk);
    @(posedge clk);
    @(negedge clk);
    d    = dout;
    en   = dout_en;
    rd_n = 1'b1;
    addr = ~a;
    @(negedge clk);
  endtask
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/10ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_count++; $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module tb;
  logic        core_clk = 1'b0;
  logic        reset, out_wr, in_rd, stat_wr, p2_wr, en_flags, in_int_en, tmr_en;
  logic        tmr_ovf, tmr_ack, halt, stop, rom_we, ram_we, host_rd_n, host_wr_n;
  logic        dout_en, kb_irq, aux_irq, a20, cpu_irq, core_run, osc_run;
  logic        wake_call, wake_next, sense0, sense1, p1b0, p1b1, en;
  logic        seen_call, seen_next;
  logic [15:0] host_addr;
  logic [10:0] rom_addr;
  logic [7:0]  host_din, host_dout, wdata, in_rdata, cpu_status, rom_rdata;
  logic [7:0]  ram_rdata, ram_addr, rd;
  logic [3:0]  pad_in, pad_out, pad_oe;
  int          err_count = 0;
  int          n_checks = 0;
  int          pbit[4] = '{6, 7, 3, 2};

  always #2 core_clk = ~core_clk;
  // external pull-ups: a pin is low only while the block pulls it
  assign pad_in = ~pad_oe;
  // wake pulses last one cycle, so latch them for later inspection
  always @(posedge core_clk) begin
    if (wake_call === 1'b1) seen_call <= 1'b1;
    if (wake_next === 1'b1) seen_next <= 1'b1;
  end

  host_io_model host_io_model_i (.clk(core_clk), .addr(host_addr), .rd_n(host_rd_n),
    .wr_n(host_wr_n), .din(host_din), .dout(host_dout), .dout_en(dout_en));

  kbd_host_mailbox kbd_host_mailbox_i (.CORE_CLK(core_clk), .RESET(reset),
    .HOST_ADDR(host_addr), .HOST_RD_N(host_rd_n), .HOST_WR_N(host_wr_n),
    .HOST_DIN(host_din), .HOST_DOUT(host_dout), .HOST_DOUT_EN(dout_en),
    .KB_HOST_IRQ(kb_irq), .AUX_HOST_IRQ(aux_irq), .A20_GATE(a20),
    .CPU_OUT_WR(out_wr), .CPU_OUT_WDATA(wdata), .CPU_IN_RD(in_rd),
    .CPU_IN_RDATA(in_rdata), .CPU_STATUS_WR(stat_wr), .CPU_STATUS_WDATA(wdata),
    .CPU_STATUS(cpu_status), .CPU_PORT2_WR(p2_wr), .CPU_PORT2_WDATA(wdata),
    .CPU_EN_FLAGS(en_flags), .CPU_IN_INT_EN(in_int_en), .CPU_TMR_INT_EN(tmr_en),
    .TIMER_OVF(tmr_ovf), .CPU_TMR_ACK(tmr_ack), .CPU_IRQ(cpu_irq), .CPU_HALT(halt),
    .CPU_STOP(stop), .CORE_RUN(core_run), .OSC_RUN(osc_run), .WAKE_CALL(wake_call),
    .WAKE_NEXT(wake_next), .ROM_WE(rom_we), .ROM_ADDR(rom_addr), .ROM_WDATA(wdata),
    .ROM_RDATA(rom_rdata), .RAM_WE(ram_we), .RAM_ADDR(ram_addr), .RAM_WDATA(wdata),
    .RAM_RDATA(ram_rdata), .KB_PAD_IN(pad_in), .KB_PAD_OUT(pad_out), .KB_PAD_OE(pad_oe),
    .SENSE_INPUT0(sense0), .SENSE_INPUT1(sense1), .PORT1_BIT0(p1b0), .PORT1_BIT1(p1b1));

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // one-cycle controller strobe: 0 out byte, 1 in read, 2 status, 3 port2, 4 flags,
  // 5 halt, 6 stop, 7 timer overflow, 8 timer ack
  task automatic cpu(input int k, input logic [7:0] d = 8'h00);
    @(negedge core_clk);
    wdata = d;
    case (k)
      0: out_wr = 1'b1;
      1: in_rd = 1'b1;
      2: stat_wr = 1'b1;
      3: p2_wr = 1'b1;
      4: en_flags = 1'b1;
      5: halt = 1'b1;
      6: stop = 1'b1;
      7: tmr_ovf = 1'b1;
      default: tmr_ack = 1'b1;
    endcase
    @(negedge core_clk);
    {out_wr, in_rd, stat_wr, p2_wr, en_flags, halt, stop, tmr_ovf, tmr_ack} = '0;
  endtask

  task automatic hold_reset();
    reset = 1'b1;
    repeat (24) @(negedge core_clk); // source holds reset 24 clocks
    reset = 1'b0;
  endtask

  // bounded wait for the core clock to come back, then let the wake pulse land
  task automatic wait_run();
    for (int i = 0; i < 300; i++) begin
      if (core_run === 1'b1) begin
        tick(2);
        return;
      end
      @(negedge core_clk);
    end
    err_count++;
    tally_and_finish();
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    {out_wr, in_rd, stat_wr, p2_wr, en_flags, halt, stop, tmr_ovf, tmr_ack} = '0;
    {in_int_en, tmr_en, rom_we, ram_we, seen_call, seen_next} = '0;
    {wdata, ram_addr, rom_addr} = '0;
    hold_reset();
    // reset state
    `CHK(cpu_status, 8'h00)
    `CHK(kb_irq, 1'b0)
    `CHK(pad_oe, 4'h0)
    host_io_model_i.io_read(16'h0064, rd, en);
    `CHK(rd, 8'h00)
    `CHK(en, 1'b1)
    // data then command write, each consumed by the controller
    host_io_model_i.io_write(16'h0060, 8'hA5);
    tick(2);
    `CHK(cpu_status, 8'h02)
    host_io_model_i.io_read(16'h0064, rd, en);
    `CHK(rd, 8'h02)
    cpu(1);
    tick(2);
    `CHK(in_rdata, 8'hA5)
    `CHK(cpu_status, 8'h00)
    host_io_model_i.io_write(16'h0064, 8'h3C);
    tick(2);
    `CHK(cpu_status, 8'h0A)
    cpu(1);
    tick(2);
    `CHK(in_rdata, 8'h3C)
    `CHK(cpu_status, 8'h08)
    // near-miss addresses are ignored
    host_io_model_i.io_write(16'h0061, 8'hFF);
    host_io_model_i.io_write(16'h0160, 8'hFF);
    tick(2);
    `CHK(cpu_status, 8'h08)
    // firmware status writes reach only the user bits
    cpu(2, 8'hFF);
    tick(2);
    `CHK(cpu_status, 8'hFC)
    host_io_model_i.io_read(16'h0064, rd, en);
    `CHK(rd, 8'hFC)
    cpu(2, 8'h00);
    tick(2);
    `CHK(cpu_status, 8'h08)
    // direct irq mode: port2 bits drive the irqs, host read leaves them alone
    cpu(0, 8'h5A);
    tick(2);
    `CHK(cpu_status, 8'h09)
    `CHK(kb_irq, 1'b0)
    cpu(3, 8'h30);
    tick(3);
    `CHK(kb_irq, 1'b1)
    `CHK(aux_irq, 1'b1)
    host_io_model_i.io_read(16'h0060, rd, en);
    tick(2);
    `CHK(rd, 8'h5A)
    `CHK(kb_irq, 1'b1)
    `CHK(cpu_status, 8'h08)
    cpu(3, 8'h00);
    tick(3);
    `CHK({kb_irq, aux_irq}, 2'b00)
    // open-drain lines and their read-back inputs
    for (int i = 0; i < 4; i++) begin
      cpu(3, 8'h01 << pbit[i]);
      tick(4);
      `CHK(pad_oe, 4'h1 << i)
      `CHK({p1b1, sense1, p1b0, sense0}, ~(4'h1 << i))
    end
    cpu(3, 8'h02);
    tick(3);
    `CHK(a20, 1'b1)
    // flag-driven mode
    cpu(4);
    cpu(3, 8'h30);
    tick(3);
    `CHK(kb_irq, 1'b0)
    `CHK(aux_irq, 1'b1)
    cpu(0, 8'hC3);
    tick(2);
    `CHK(kb_irq, 1'b1)
    host_io_model_i.io_read(16'h0060, rd, en);
    tick(2);
    `CHK(rd, 8'hC3)
    `CHK(kb_irq, 1'b0)
    host_io_model_i.io_write(16'h0060, 8'h11);
    tick(2);
    `CHK(aux_irq, 1'b0)
    cpu(1);
    tick(2);
    `CHK(aux_irq, 1'b1)
    cpu(0, 8'h22);
    cpu(3, 8'h20);
    tick(3);
    `CHK(kb_irq, 1'b0)
    host_io_model_i.io_read(16'h0060, rd, en);
    // timer interrupt source
    tmr_en = 1'b1;
    cpu(7);
    tick(2);
    `CHK(cpu_irq, 1'b1)
    cpu(8);
    tick(2);
    `CHK(cpu_irq, 1'b0)
    tmr_en = 1'b0;
    // soft powerdown, woken by a host write with and without the input interrupt
    in_int_en = 1'b1;
    cpu(5);
    tick(1);
    `CHK(core_run, 1'b0)
    {seen_call, seen_next} = 2'b00;
    host_io_model_i.io_write(16'h0060, 8'h01);
    wait_run();
    `CHK({seen_call, seen_next}, 2'b10)
    `CHK(cpu_irq, 1'b1)
    cpu(1);
    tick(2);
    `CHK(cpu_irq, 1'b0)
    in_int_en = 1'b0;
    cpu(5);
    {seen_call, seen_next} = 2'b00;
    host_io_model_i.io_write(16'h0060, 8'h02);
    wait_run();
    `CHK({seen_call, seen_next}, 2'b01)
    cpu(1);
    // hard powerdown: oscillator off until a host write, then settling
    cpu(6);
    tick(1);
    `CHK(osc_run, 1'b0)
    host_io_model_i.io_write(16'h0064, 8'h03);
    wait_run();
    `CHK(osc_run, 1'b1)
    // hard powerdown left through reset
    cpu(6);
    tick(1);
    hold_reset();
    tick(1);
    `CHK({core_run, osc_run}, 2'b11)
    `CHK(cpu_status, 8'h00)
    // program and data memories at their top addresses
    rom_addr = 11'h7FF;
    ram_addr = 8'hFF;
    wdata = 8'h9E;
    {rom_we, ram_we} = 2'b11;
    tick(1);
    {rom_we, ram_we} = 2'b00;
    tick(2);
    `CHK({rom_rdata, ram_rdata}, 16'h9E9E)
    tally_and_finish();
  end

  // hang guard: running out counts as a mismatch
  initial begin
    #400000;
    err_count++;
    tally_and_finish();
  end
endmodule
